// >>> logic/scr_consts.svh
// Constants for the calibration pattern read and loop-off control block
`ifndef SCR_CONSTS_SVH
`define SCR_CONSTS_SVH
`define SCR_CMD_MRS 3'h0
`define SCR_CMD_READ 3'h5
`define SCR_CMD_NOP 3'h7
`define SCR_MR_ONE 3'h1
`define SCR_MR_THREE 3'h3
`define SCR_MR_ZERO 3'h0
`define SCR_MR1_LOOP_OFF_BIT 0
`define SCR_MR3_PATTERN_EN_BIT 2
`define SCR_MR0_CHOP_LO_BIT 0
`define SCR_MR0_CHOP_HI_BIT 1
`define SCR_CHOP_ON_THE_FLY 2'h1
`define SCR_CHOP_FIXED 2'h2
`define SCR_ADDR_CHOP_BIT 12
`define SCR_ADDR_NIBBLE_BIT 2
`define SCR_PATTERN_LOC0 2'h0
`define SCR_PATTERN_BITS 8'hAA
`define SCR_READ_LATENCY 4'h6
`define SCR_LOOP_OFF_SHIFT 4'h1
`define SCR_BEATS_FULL 4'h8
`define SCR_BEATS_CHOP 4'h4
`endif

// >>> logic/scr_pkg.sv
// Types for the calibration pattern read and loop-off control block
package scr_pkg;
  typedef enum logic [1:0] {
    SCR_IDLE = 2'b00,
    SCR_WAIT = 2'b01,
    SCR_BURST = 2'b11
  } scr_state_type;
  typedef struct packed {
    logic [1:0] clk_sync;
    logic clk_prev;
    logic [1:0][3:0] pins_sync;
    logic [1:0][2:0] bank_sync;
    logic [1:0][13:0] addr_sync;
    scr_state_type state;
    logic loop_off;
    logic pattern_en;
    logic [1:0] pattern_loc;
    logic [1:0] chop_mode;
    logic [3:0] wait_cnt;
    logic [3:0] beat_cnt;
    logic [2:0] beat_idx;
    logic [3:0] beats_total;
    logic [7:0] pattern;
  } scr_ctrl_state_type;
  typedef struct packed {
    logic [1:0] cnt;
    logic [1:0] wr_ptr;
    logic [1:0] rd_ptr;
    logic [1:0][15:0] mem;
    logic valid_out;
    logic [15:0] data_out;
  } scr_buf_state_type;
endpackage

// >>> logic/scr_beat_buffer.sv
// Two-entry beat buffer with valid and ready on both sides
`timescale 1ns/100ps
module scr_beat_buffer
  import scr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [15:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [15:0] out_data
);
  scr_buf_state_type cur_ff;
  scr_buf_state_type nxt_ff;
  logic push;
  logic pop;
  // Handshakes
  assign in_ready = (cur_ff.cnt != 2'h2);
  assign push = in_valid && in_ready;
  assign pop = cur_ff.valid_out && out_ready;
  assign out_valid = cur_ff.valid_out;
  assign out_data = cur_ff.data_out;
  // Pointer and storage update
  always_comb begin
    nxt_ff = cur_ff;
    if (push) begin
      nxt_ff.mem[cur_ff.wr_ptr[0]] = in_data;
      nxt_ff.wr_ptr = cur_ff.wr_ptr + 2'h1;
    end
    if (pop) begin
      nxt_ff.rd_ptr = cur_ff.rd_ptr + 2'h1;
    end
    nxt_ff.cnt = cur_ff.cnt + {1'b0, push} - {1'b0, pop};
    // Output register shows head entry
    nxt_ff.valid_out = (nxt_ff.cnt != 2'h0);
    nxt_ff.data_out = nxt_ff.mem[nxt_ff.rd_ptr[0]];
  end
  // State register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end
endmodule // scr_beat_buffer

// >>> logic/scr_calib_read_ctrl.sv
// Calibration pattern read, command decode and loop-off read timing
// Summary of operation
// - Bit zero pattern copied across both lanes
// - Bank and high column bits ignored
// - Eight-beat read returns beats zero to seven
// - Chopped read picks nibble from A2
// - Chop fixed or chosen per read by A12
// - Pattern reads use normal read latency
// - Beat zero is pattern least significant bit
// - Location zero gives alternating pattern, others reserved
// - NOP registers no new command
// - Deselect executes no new command
// - Mode one bit zero turns loop off
// - Loop-off supports read latency six only; code takes one off any latency, added latency included
// - Loop-off strobe starts one cycle early
// - Mode three bit two enables pattern reads
// - Read with auto close acts as read
`timescale 1ns/100ps
`include "scr_consts.svh"
module scr_calib_read_ctrl
  import scr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic mem_clk,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] bank_addr,
  input wire logic [13:0] addr,
  input wire logic [3:0] added_latency,
  output logic lower_byte_lane_valid,
  output logic [7:0] lower_byte_lane,
  output logic [7:0] upper_byte_lane,
  input wire logic lane_ready,
  output logic strobe_active,
  output logic loop_off_ff,
  output logic pattern_en_ff
);
  // ************************************************************
  // Command sampling and state
  // ************************************************************
  scr_ctrl_state_type cur_ff;
  scr_ctrl_state_type nxt_ff;
  logic clk_rise;
  logic cs_n_sync;
  logic ras_n_sync;
  logic cas_n_sync;
  logic we_n_sync;
  logic [2:0] cmd_code;
  logic [2:0] bank_sync;
  logic [13:0] addr_sync;
  logic cmd_mrs;
  logic cmd_read;
  logic chop_fixed;
  logic chop_otf;
  logic chop_sel;
  logic [2:0] first_beat;
  logic [7:0] pattern_sel;
  logic buf_ready;
  logic buf_valid;
  logic [15:0] buf_data;
  logic [3:0] lat_base;
  logic [3:0] lat_cycles;
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Edge of synchronised memory clock
  assign clk_rise = cur_ff.clk_sync[1] && !cur_ff.clk_prev;
  // Second stage of the command and address synchronisers
  assign cs_n_sync = cur_ff.pins_sync[1][3];
  assign ras_n_sync = cur_ff.pins_sync[1][2];
  assign cas_n_sync = cur_ff.pins_sync[1][1];
  assign we_n_sync = cur_ff.pins_sync[1][0];
  assign bank_sync = cur_ff.bank_sync[1];
  assign addr_sync = cur_ff.addr_sync[1];
  // ************************************************************
  // Command decode
  // ************************************************************
  // Row, column and write strobes form the command code
  assign cmd_code = {ras_n_sync, cas_n_sync, we_n_sync};
  // Chip select high or NOP decode to no command
  assign cmd_mrs = clk_rise && !cs_n_sync && (cmd_code == `SCR_CMD_MRS);
  // Read and read with auto close alike; A10 ignored
  assign cmd_read = clk_rise && !cs_n_sync && (cmd_code == `SCR_CMD_READ);
  // Chop fixed by mode, or per read with chop bit low
  assign chop_fixed = (cur_ff.chop_mode == `SCR_CHOP_FIXED);
  assign chop_otf = (cur_ff.chop_mode == `SCR_CHOP_ON_THE_FLY) && !addr_sync[`SCR_ADDR_CHOP_BIT];
  assign chop_sel = chop_fixed || chop_otf;
  // Chopped read starts at nibble from A2, full burst at beat zero
  assign first_beat = chop_sel ? {addr_sync[`SCR_ADDR_NIBBLE_BIT], 2'h0} : 3'h0;
  // Location zero pattern, reserved ones read zero
  assign pattern_sel = (cur_ff.pattern_loc == `SCR_PATTERN_LOC0) ? `SCR_PATTERN_BITS : 8'h00;
  // Normal read latency applies to pattern reads
  assign lat_base = added_latency + `SCR_READ_LATENCY;
  // Strobe starts one memory clock early with loop off
  assign lat_cycles = cur_ff.loop_off ? (lat_base - `SCR_LOOP_OFF_SHIFT) : lat_base;
  // ************************************************************
  // Mode and burst sequencing
  // ************************************************************
  // Next state
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.clk_sync = {cur_ff.clk_sync[0], mem_clk};
    nxt_ff.clk_prev = cur_ff.clk_sync[1];
    // Two flip-flops on every command and address pin
    nxt_ff.pins_sync = {cur_ff.pins_sync[0], {cs_n, ras_n, cas_n, we_n}};
    nxt_ff.bank_sync = {cur_ff.bank_sync[0], bank_addr};
    nxt_ff.addr_sync = {cur_ff.addr_sync[0], addr};
    // Mode register capture; bank bits select register
    if (cmd_mrs) begin
      // Loop control in mode one
      if (bank_sync == `SCR_MR_ONE) begin
        nxt_ff.loop_off = addr_sync[`SCR_MR1_LOOP_OFF_BIT];
      end
      // Pattern enable and location in mode three
      if (bank_sync == `SCR_MR_THREE) begin
        nxt_ff.pattern_en = addr_sync[`SCR_MR3_PATTERN_EN_BIT];
        nxt_ff.pattern_loc = addr_sync[1:0];
      end
      // Chop mode in mode zero
      if (bank_sync == `SCR_MR_ZERO) begin
        nxt_ff.chop_mode = addr_sync[`SCR_MR0_CHOP_HI_BIT:`SCR_MR0_CHOP_LO_BIT];
      end
    end
    unique case (cur_ff.state)
      SCR_IDLE: begin
        // Only A2 and chop bit steer; bank bits ignored
        if (cmd_read && cur_ff.pattern_en) begin
          nxt_ff.state = SCR_WAIT;
          nxt_ff.wait_cnt = lat_cycles;
          // First beat from nibble select
          nxt_ff.beat_idx = first_beat;
          // Four beats when chopped, else eight
          if (chop_sel) begin
            nxt_ff.beats_total = `SCR_BEATS_CHOP;
          end else begin
            nxt_ff.beats_total = `SCR_BEATS_FULL;
          end
          // Pattern of the selected location
          nxt_ff.pattern = pattern_sel;
          nxt_ff.beat_cnt = 4'h0;
        end
      end
      SCR_WAIT: begin
        // Count memory clock rises to strobe start
        if (clk_rise) begin
          if (cur_ff.wait_cnt <= 4'h1) begin
            nxt_ff.state = SCR_BURST;
          end else begin
            nxt_ff.wait_cnt = cur_ff.wait_cnt - 4'h1;
          end
        end
      end
      SCR_BURST: begin
        // One beat per core clock, stalls on buffer full
        if (buf_ready) begin
          nxt_ff.beat_idx = cur_ff.beat_idx + 3'h1;
          nxt_ff.beat_cnt = cur_ff.beat_cnt + 4'h1;
          if (cur_ff.beat_cnt + 4'h1 == cur_ff.beats_total) begin
            nxt_ff.state = SCR_IDLE;
          end
        end
      end
      default: begin
        nxt_ff.state = SCR_IDLE;
      end
    endcase
  end
  // ************************************************************
  // Beat data and buffer
  // ************************************************************
  logic beat_bit;
  logic [15:0] beat_word;
  // Beat index picks pattern bit, LSB first
  assign beat_bit = cur_ff.pattern[cur_ff.beat_idx];
  // Bit zero of each lane carries pattern, others copy
  assign beat_word = {16{beat_bit}};
  scr_beat_buffer u_buf (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(cur_ff.state == SCR_BURST),
    .in_ready(buf_ready),
    .in_data(beat_word),
    .out_valid(buf_valid),
    .out_ready(lane_ready),
    .out_data(buf_data)
  );
  // ************************************************************
  // State and output registers
  // ************************************************************
  // State register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end
  // Registered outputs
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lower_byte_lane_valid <= 1'b0;
      lower_byte_lane <= 8'h00;
      upper_byte_lane <= 8'h00;
      strobe_active <= 1'b0;
      loop_off_ff <= 1'b0;
      pattern_en_ff <= 1'b0;
    end else begin
      lower_byte_lane_valid <= buf_valid && lane_ready;
      lower_byte_lane <= buf_data[7:0];
      upper_byte_lane <= buf_data[15:8];
      strobe_active <= (cur_ff.state == SCR_BURST);
      loop_off_ff <= cur_ff.loop_off;
      pattern_en_ff <= cur_ff.pattern_en;
    end
  end
endmodule // scr_calib_read_ctrl

// >>> testbench/scr_ctrl_model.sv
// Memory controller model driving the memory clock and command pins
`timescale 1ns/100ps
module scr_ctrl_model (
  output logic mem_clk,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] bank_addr,
  output logic [13:0] addr
);
  initial begin
    mem_clk = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    bank_addr = 3'h0;
    addr = 14'h0;
  end
  // Free-running clock, slow enough for loop-off operation
  always #62.5 mem_clk = ~mem_clk;
  // Clock enable stays high, termination off; no self refresh modelled
  // One command for one memory clock, then NOP with inverted address
  task automatic issue(input logic [3:0] pins, input logic [2:0] ba, input logic [13:0] a);
    @(negedge mem_clk);
    {cs_n, ras_n, cas_n, we_n} = pins;
    bank_addr = ba;
    addr = a;
    @(negedge mem_clk);
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    bank_addr = ~ba;
    addr = ~a;
  endtask
endmodule // scr_ctrl_model

// >>> testbench/scr_calib_read_monitor.sv
// Checker of lane data, mode status and beat gating
`timescale 1ns/100ps
module scr_calib_read_monitor (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic [2:0] bank_addr,
  input wire logic [13:0] addr,
  input wire logic lower_byte_lane_valid,
  input wire logic [7:0] lower_byte_lane,
  input wire logic [7:0] upper_byte_lane,
  input wire logic strobe_active,
  input wire logic lane_ready,
  input wire logic loop_off_ff,
  input wire logic pattern_en_ff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Mode status changes only on a mode set to the right register
  property p_loop_cmd; $changed(loop_off_ff) |-> !$past(cs_n, 4) && !$past(ras_n, 4); endproperty
  a_loop_cmd: assert property (p_loop_cmd) else $error("loop status changed without command");
  property p_loop_src; $changed(loop_off_ff) |-> $past(bank_addr, 4) == 3'h1 && $past(addr[0], 4) == loop_off_ff;
  endproperty
  a_loop_src: assert property (p_loop_src) else $error("loop status source wrong");
  property p_pat_cmd; $changed(pattern_en_ff) |-> !$past(cs_n, 4) && !$past(ras_n, 4); endproperty
  a_pat_cmd: assert property (p_pat_cmd) else $error("pattern status changed without command");
  property p_pat_src; $changed(pattern_en_ff) |-> $past(bank_addr, 4) == 3'h3 && $past(addr[2], 4) == pattern_en_ff;
  endproperty
  a_pat_src: assert property (p_pat_src) else $error("pattern status source wrong");
  // Beats are copies of one bit and only in pattern mode
  property p_lane_copy; lower_byte_lane_valid |-> lower_byte_lane == upper_byte_lane &&
    (lower_byte_lane == 8'h00 || lower_byte_lane == 8'hFF); endproperty
  a_lane_copy: assert property (p_lane_copy) else $error("lane data not a bit copy");
  property p_beat_gate; lower_byte_lane_valid |-> pattern_en_ff; endproperty
  a_beat_gate: assert property (p_beat_gate) else $error("beat outside pattern mode");
  property p_strobe_data; $rose(strobe_active) && lane_ready |-> ##[1:6] lower_byte_lane_valid; endproperty
  a_strobe_data: assert property (p_strobe_data) else $error("no beat after strobe");
  property p_strobe_len; $rose(strobe_active) |-> strobe_active [*3]; endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe too short");
  c_burst: cover property ($rose(strobe_active));
  c_pattern: cover property ($rose(pattern_en_ff));
  c_loop_off: cover property ($rose(loop_off_ff));
endmodule // scr_calib_read_monitor
bind scr_calib_read_ctrl scr_calib_read_monitor u_scr_calib_read_monitor (.core_clk(core_clk), .reset_n(reset_n),
  .cs_n(cs_n), .ras_n(ras_n), .bank_addr(bank_addr), .addr(addr), .lower_byte_lane_valid(lower_byte_lane_valid),
  .lower_byte_lane(lower_byte_lane), .upper_byte_lane(upper_byte_lane), .strobe_active(strobe_active),
  .lane_ready(lane_ready), .loop_off_ff(loop_off_ff), .pattern_en_ff(pattern_en_ff));

// >>> testbench/scr_calib_read_ctrl_tb.sv
// Testbench for calibration pattern reads and loop-off timing
`timescale 1ns/100ps
module scr_calib_read_ctrl_tb;
  logic core_clk = 1'b0, reset_n = 1'b0, lane_ready = 1'b1;
  logic [3:0] added_latency = 4'h0;
  logic mem_clk, cs_n, ras_n, cas_n, we_n, vld, strobe_active, loop_off_ff, pattern_en_ff;
  logic [2:0] bank_addr;
  logic [13:0] addr;
  logic [7:0] lo, hi;
  logic [15:0] q[$];
  int error_cnt = 0, n_checks = 0, mrise = 0, cyc = 0;
  always #4 core_clk = ~core_clk;
  always @(posedge mem_clk) mrise++;
  // Collect delivered beats and cut a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (vld && lane_ready) q.push_back({hi, lo});
    if (cyc == 10000) begin
      error_cnt++;
      wrap_up();
    end
  end
  scr_ctrl_model u_scr_ctrl_model (.mem_clk(mem_clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_addr(bank_addr), .addr(addr));
  scr_calib_read_ctrl u_scr_calib_read_ctrl (.core_clk(core_clk), .reset_n(reset_n), .mem_clk(mem_clk),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr), .addr(addr),
    .added_latency(added_latency), .lower_byte_lane_valid(vld), .lower_byte_lane(lo), .upper_byte_lane(hi),
    .lane_ready(lane_ready), .strobe_active(strobe_active), .loop_off_ff(loop_off_ff), .pattern_en_ff(pattern_en_ff));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmd(input logic [3:0] pins, input logic [2:0] ba, input logic [13:0] a);
    u_scr_ctrl_model.issue(pins, ba, a);
    repeat (20) @(negedge core_clk);
  endtask
  // Read with optional receiver stall; checks latency in memory clocks and beats
  task automatic rd(input logic [13:0] a, input int n, input logic [7:0] exp, input int lat, input bit stall);
    int r0;
    int w;
    q.delete();
    lane_ready = !stall;
    u_scr_ctrl_model.issue(4'h5, 3'h7, a);
    r0 = mrise;
    w = 0;
    while (strobe_active !== 1'b1 && w < 300) begin
      @(negedge core_clk);
      w++;
    end
    if (lat >= 0) check("latency", 16'(mrise - r0), 16'(lat));
    repeat (40) @(negedge core_clk);
    lane_ready = 1'b1;
    repeat (100) @(negedge core_clk);
    check("beats", 16'(q.size()), 16'(n));
    foreach (q[k]) check("beat", q[k], {16{exp[k]}});
  endtask
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge core_clk);
    check("loop_off", {15'h0, loop_off_ff}, 16'h0);
    check("pattern_en", {15'h0, pattern_en_ff}, 16'h0);
    rd(14'h0, 0, 8'h00, -1, 1'b0);
    $display("Test refused read done");
    cmd(4'h0, 3'h3, 14'h4);
    check("pattern_en", {15'h0, pattern_en_ff}, 16'h1);
    cmd(4'h8, 3'h3, 14'h0);
    check("deselect", {15'h0, pattern_en_ff}, 16'h1);
    cmd(4'h7, 3'h3, 14'h0);
    check("nop", {15'h0, pattern_en_ff}, 16'h1);
    $display("Test mode entry done");
    // Reads only long after reset and mode set, loop counted as locked
    rd(14'h2FF8, 8, 8'hAA, 6, 1'b1);
    cmd(4'h0, 3'h0, 14'h1);
    rd(14'h0004, 4, 8'hAA, 6, 1'b0);
    rd(14'h0000, 4, 8'hAA, 6, 1'b0);
    rd(14'h1000, 8, 8'hAA, 6, 1'b0);
    cmd(4'h0, 3'h0, 14'h2);
    rd(14'h1000, 4, 8'hAA, 6, 1'b0);
    cmd(4'h0, 3'h0, 14'h0);
    $display("Test chop done");
    added_latency = 4'h2;
    rd(14'h0, 8, 8'hAA, 8, 1'b0);
    added_latency = 4'h0;
    cmd(4'h0, 3'h3, 14'h5);
    rd(14'h0, 8, 8'h00, 6, 1'b0);
    cmd(4'h0, 3'h3, 14'h4);
    cmd(4'h0, 3'h1, 14'h1);
    check("loop_off", {15'h0, loop_off_ff}, 16'h1);
    cmd(4'h0, 3'h0, 14'h0);
    check("loop_off_kept", {15'h0, loop_off_ff}, 16'h1);
    rd(14'h0, 8, 8'hAA, 5, 1'b0);
    $display("Test latency done");
    wrap_up();
  end
endmodule // scr_calib_read_ctrl_tb
